// [rtl/bidir_send_pkg.sv]
package bidir_send_pkg;

	// Clock and the busy time of a channel-setting or init command
	localparam int CLK_NS = 20;
	localparam int CFG_BUSY_NS = 1000;
	localparam int CFG_BUSY_CYC = (CFG_BUSY_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] CFG_CNT_LOAD = 8'(CFG_BUSY_CYC);

	// Register byte offsets
	localparam logic [11:0] OFF_CMD = 12'h000;
	localparam logic [11:0] OFF_SEND_LEN = 12'h004;
	localparam logic [11:0] OFF_DATA_WR = 12'h008;
	localparam logic [11:0] OFF_CONFIG = 12'h00c;
	localparam logic [11:0] OFF_RESULT1 = 12'h010;
	localparam logic [11:0] OFF_RESULT2 = 12'h014;
	localparam logic [11:0] OFF_COMPLETION = 12'h018;
	localparam logic [11:0] OFF_SCAN_END = 12'h01c;
	localparam logic [11:0] OFF_CPU_ERR = 12'h020;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h024;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h028;
	localparam logic [11:0] OFF_IRQ_ENABLE = 12'h02c;
	localparam logic [11:0] OFF_CMD_RESULT = 12'h030;

	// Field positions
	localparam int CMD_CHAN_LSB = 4;
	localparam int CMD_SIO_LSB = 8;
	localparam int DATA_IDX_LSB = 16;
	localparam int DATA_CH_BIT = 31;

	// Channel selector values in control word zero
	localparam logic [1:0] first_channel = 2'h1;
	localparam logic [1:0] second_channel = 2'h2;

	// Result codes
	localparam logic [15:0] RESULT_NORMAL = 16'h0000;
	localparam logic [15:0] ERR_SIMUL_EXEC = 16'h7ff0;
	localparam logic [15:0] ERR_PROTOCOL = 16'h7ff2;
	localparam logic [15:0] ERR_CHANNEL = 16'h7f10;
	localparam logic [15:0] ERR_LENGTH = 16'h7f11;
	localparam logic [15:0] ERR_LINK = 16'h7f12;

	// Reset values
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [4:0] RST_IRQ = 5'h00;
	localparam logic [7:0] RST_CNT = 8'h00;

	typedef enum logic [3:0] {
		bidir_send_cmd = 4'h1,
		bidir_receive_cmd = 4'h2,
		channel_setting_cmd = 4'h3,
		interface_init_cmd = 4'h4,
		on_demand_send_cmd = 4'h5,
		nonproc_send_cmd = 4'h6,
		nonproc_receive_cmd = 4'h7,
		user_frame_send_cmd = 4'h8,
		protocol_exec_cmd = 4'h9,
		remote_file_read_cmd = 4'ha,
		remote_file_write_cmd = 4'hb,
		buffer_receive_cmd = 4'hc,
		busy_query_cmd = 4'hd
	} cmd_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_FETCH = 3'h1,
		TX_SEND = 3'h3,
		TX_RELEASE = 3'h2,
		TX_DONE = 3'h6
	} tx_state_t;

endpackage

// [rtl/scan_end_reporter.sv]
`timescale 1ns/1ns
module scan_end_reporter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic event_in,
	input wire logic event_err,
	input wire logic scan_end,
	output logic done_r,
	output logic abn_r
);

	logic pend_r;
	logic pend_err_r;

	// An event in the scan-end cycle still belongs to this scan
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r <= 1'b0;
			pend_err_r <= 1'b0;
			done_r <= 1'b0;
			abn_r <= 1'b0;
		end else if (scan_end) begin
			pend_r <= 1'b0;
			pend_err_r <= 1'b0;
			done_r <= pend_r | event_in; // RL9
			abn_r <= pend_err_r | (event_in & event_err); // RL10
		end else begin
			pend_r <= pend_r | event_in;
			pend_err_r <= pend_err_r | (event_in & event_err);
		end
	end

	AST_DONE_AT_SCAN_END: assert property ( // RL9
		@(posedge pclk) disable iff (!presetn)
		(done_r != $past(done_r)) |-> $past(scan_end))
		else $error("completion bit moved outside scan end");

	AST_DONE_ONE_SCAN: assert property ( // RL9
		@(posedge pclk) disable iff (!presetn)
		(scan_end && done_r && !pend_r && !event_in) |=> !done_r)
		else $error("completion bit held past next scan end");

	AST_ABN_ALIGNED: assert property ( // RL10
		@(posedge pclk) disable iff (!presetn)
		abn_r |-> done_r)
		else $error("abnormal bit without completion bit");

endmodule

// [rtl/bidir_tx_channel.sv]
`timescale 1ns/1ns
module bidir_tx_channel #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_idx,
	input wire logic [W-1:0] wr_data,
	input wire logic start,
	input wire logic [15:0] len,
	input wire logic byte_units,
	input wire logic link_ack,
	input wire logic link_fault,
	output logic [W-1:0] tx_data_r,
	output logic tx_valid_r,
	output logic busy,
	output logic fin_r,
	output logic fin_err,
	output logic [15:0] fin_code_r
);

	logic [W-1:0] mem [DEPTH];
	bidir_send_pkg::tx_state_t state_r;
	bidir_send_pkg::tx_state_t state_nxt;
	logic [15:0] left_r;
	logic [AW-1:0] rd_idx_r;

	// Byte units round up to whole words
	wire [16:0] len_half = ({1'b0, len} + 17'h00001) >> 1;
	wire [15:0] len_words = byte_units ? len_half[15:0] : len;
	wire len_bad = (len_words == 16'h0000) || (len_words > 16'(DEPTH));

	assign busy = (state_r != bidir_send_pkg::TX_IDLE);
	assign fin_err = (fin_code_r != bidir_send_pkg::RESULT_NORMAL);

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			bidir_send_pkg::TX_IDLE: begin
				if (start) begin
					state_nxt = len_bad ? bidir_send_pkg::TX_DONE :
						bidir_send_pkg::TX_FETCH;
				end
			end
			bidir_send_pkg::TX_FETCH: state_nxt = bidir_send_pkg::TX_SEND;
			bidir_send_pkg::TX_SEND: begin
				if (link_fault) begin
					state_nxt = bidir_send_pkg::TX_DONE;
				end else if (link_ack) begin
					state_nxt = bidir_send_pkg::TX_RELEASE;
				end
			end
			bidir_send_pkg::TX_RELEASE: begin
				if (link_fault || (!link_ack && left_r == 16'h0000)) begin
					state_nxt = bidir_send_pkg::TX_DONE;
				end else if (!link_ack) begin
					state_nxt = bidir_send_pkg::TX_FETCH;
				end
			end
			bidir_send_pkg::TX_DONE: state_nxt = bidir_send_pkg::TX_IDLE;
			default: state_nxt = bidir_send_pkg::TX_IDLE;
		endcase
	end

	// Four-phase word handshake: valid up, ack up, valid down, ack down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= bidir_send_pkg::TX_IDLE;
			left_r <= bidir_send_pkg::RST_HALF;
			rd_idx_r <= '0;
			tx_data_r <= '0;
			tx_valid_r <= 1'b0;
			fin_r <= 1'b0;
			fin_code_r <= bidir_send_pkg::RESULT_NORMAL;
		end else begin
			state_r <= state_nxt;
			fin_r <= (state_nxt == bidir_send_pkg::TX_DONE);
			if (state_r == bidir_send_pkg::TX_IDLE && start) begin
				left_r <= len_words;
				rd_idx_r <= '0;
				fin_code_r <= len_bad ? bidir_send_pkg::ERR_LENGTH : // RL3
					bidir_send_pkg::RESULT_NORMAL;
			end
			if (state_r == bidir_send_pkg::TX_FETCH) begin
				tx_data_r <= mem[rd_idx_r]; // RL5
				tx_valid_r <= 1'b1;
				left_r <= left_r - 16'h0001;
				rd_idx_r <= rd_idx_r + 1'b1;
			end
			if (state_r == bidir_send_pkg::TX_SEND && (link_ack || link_fault)) begin
				tx_valid_r <= 1'b0;
			end
			if (link_fault && (state_r == bidir_send_pkg::TX_SEND ||
				state_r == bidir_send_pkg::TX_RELEASE)) begin
				fin_code_r <= bidir_send_pkg::ERR_LINK; // RL3
			end
		end
	end

	AST_TX_DATA_STABLE: assert property ( // RL5
		@(posedge pclk) disable iff (!presetn)
		(tx_valid_r && !link_ack && !link_fault) |=>
			(tx_valid_r && tx_data_r == $past(tx_data_r)))
		else $error("send word changed before acknowledge");

	AST_LEN_ERROR: assert property ( // RL3
		@(posedge pclk) disable iff (!presetn)
		(state_r == bidir_send_pkg::TX_IDLE && start && len_bad) |=>
			(fin_r && fin_code_r == bidir_send_pkg::ERR_LENGTH))
		else $error("bad length not reported at once");

endmodule

// [rtl/bidir_send_handler.sv]
`timescale 1ns/1ns
//
// Contract
// [RL1] The requester addresses the module by a start I/O number 00 to FE.
// [RL2] Control word zero picks the channel, 1 for the first, 2 the second.
// [RL3] At completion the result word gets zero or a nonzero error code.
// [RL4] The requester gives a length of one or more, in bytes or words.
// [RL5] The module sends the source data over the selected channel.
// [RL6] A second send on a busy channel is ignored; others run in parallel.
// [RL7] Channel-setting or init colliding with a send fails the later one.
// [RL8] Other-protocol commands on a sending channel report error 7ff2.
// [RL9] Completion bit rises at the finishing scan end, falls at the next.
// [RL10] Abnormal bit stays off on success, pulses with completion on error.
// [RL11] A failed command raises the abnormal bit and stores its error code; only failed sends raise it, not setting/protocol/channel rejects.
// [RL12] An operation error sets the CPU error flag and its code word.
// [RL13] Receive, remote, buffer and busy-query commands run alongside.
// [RL14] Arbitration state is kept apart for each of the two channels.
module bidir_send_handler #(
	parameter logic [7:0] MODULE_START_IO = 8'h00,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [1:0][15:0] tx_data,
	output logic [1:0] tx_valid,
	input wire logic [1:0] tx_ack,
	input wire logic [1:0] tx_fault,
	output logic [1:0] done_bit,
	output logic [1:0] abnormal_bit,
	output logic cpu_error_flag,
	output logic [15:0] cpu_error_code_word,
	output logic irq
);

	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [15:0] send_len_r;
	logic byte_units_r;
	logic [1:0][15:0] result_r;
	logic [1:0][7:0] cfg_cnt_r;
	logic [15:0] cmd_result_r;
	logic cpu_err_flag_r;
	logic [15:0] cpu_err_code_r;
	logic [4:0] irq_st_r;
	logic [4:0] irq_en_r;
	logic irq_r;
	logic [1:0] ack_m_r;
	logic [1:0] ack_s_r;
	logic [1:0] flt_m_r;
	logic [1:0] flt_s_r;

	// APB decode
	wire acc = psel & penable;
	wire xfer = acc & pready_r;
	wire a_cmd = (paddr == bidir_send_pkg::OFF_CMD);
	wire a_len = (paddr == bidir_send_pkg::OFF_SEND_LEN);
	wire a_data = (paddr == bidir_send_pkg::OFF_DATA_WR);
	wire a_cfg = (paddr == bidir_send_pkg::OFF_CONFIG);
	wire a_res1 = (paddr == bidir_send_pkg::OFF_RESULT1);
	wire a_res2 = (paddr == bidir_send_pkg::OFF_RESULT2);
	wire a_comp = (paddr == bidir_send_pkg::OFF_COMPLETION);
	wire a_scan = (paddr == bidir_send_pkg::OFF_SCAN_END);
	wire a_cpu = (paddr == bidir_send_pkg::OFF_CPU_ERR);
	wire a_ist = (paddr == bidir_send_pkg::OFF_IRQ_STATUS);
	wire a_iclr = (paddr == bidir_send_pkg::OFF_IRQ_CLEAR);
	wire a_ien = (paddr == bidir_send_pkg::OFF_IRQ_ENABLE);
	wire a_cres = (paddr == bidir_send_pkg::OFF_CMD_RESULT);
	wire hit = a_cmd | a_len | a_data | a_cfg | a_res1 | a_res2 | a_comp |
		a_scan | a_cpu | a_ist | a_iclr | a_ien | a_cres;
	wire wr = xfer & pwrite & hit;
	wire scan_end = wr & a_scan;

	wire [1:0] send_busy;
	wire [1:0] fin;
	wire [1:0] fin_err;
	wire [1:0][15:0] fin_code;
	wire [1:0] rep_done;
	wire [1:0] rep_abn;

	wire [31:0] rd_val =
		a_len ? {16'h0000, send_len_r} :
		a_cfg ? {31'h00000000, byte_units_r} :
		a_res1 ? {16'h0000, result_r[0]} :
		a_res2 ? {16'h0000, result_r[1]} :
		a_comp ? {26'h0000000, send_busy, rep_abn, rep_done} :
		a_cpu ? {15'h0000, cpu_err_flag_r, cpu_err_code_r} :
		a_ist ? {27'h0000000, irq_st_r} :
		a_ien ? {27'h0000000, irq_en_r} :
		a_cres ? {16'h0000, cmd_result_r} : 32'h00000000;

	// Command decode
	wire [3:0] cmd_code = pwdata[3:0];
	wire [1:0] cmd_chan = pwdata[bidir_send_pkg::CMD_CHAN_LSB +: 2];
	wire for_me = (pwdata[bidir_send_pkg::CMD_SIO_LSB +: 8] ==
		MODULE_START_IO); // RL1
	wire issue = wr & a_cmd & for_me;
	wire chan_ok = (cmd_chan == bidir_send_pkg::first_channel) |
		(cmd_chan == bidir_send_pkg::second_channel); // RL2
	wire chan_bad = issue & !chan_ok;
	wire is_send = (cmd_code == bidir_send_pkg::bidir_send_cmd);
	wire is_cfg = (cmd_code == bidir_send_pkg::channel_setting_cmd) |
		(cmd_code == bidir_send_pkg::interface_init_cmd);
	wire is_proto = (cmd_code == bidir_send_pkg::on_demand_send_cmd) |
		(cmd_code == bidir_send_pkg::nonproc_send_cmd) |
		(cmd_code == bidir_send_pkg::nonproc_receive_cmd) |
		(cmd_code == bidir_send_pkg::user_frame_send_cmd) |
		(cmd_code == bidir_send_pkg::protocol_exec_cmd);
	// Receive, remote, buffer and busy query fall through as accepted

	wire [1:0] sel;
	wire [1:0] cfg_busy;
	wire [1:0] start;
	wire [1:0] rej_send;
	wire [1:0] cfg_rej;
	wire [1:0] cfg_load;
	wire [1:0] proto_rej;
	wire [1:0] ev;
	wire [1:0] ev_err;
	wire [1:0] wr_en;

	assign sel[0] = issue & (cmd_chan == bidir_send_pkg::first_channel);
	assign sel[1] = issue & (cmd_chan == bidir_send_pkg::second_channel);

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			assign cfg_busy[c] = (cfg_cnt_r[c] != bidir_send_pkg::RST_CNT);
			assign start[c] = sel[c] & is_send & !send_busy[c] &
				!cfg_busy[c]; // RL6 RL14
			assign rej_send[c] = sel[c] & is_send & !send_busy[c] &
				cfg_busy[c]; // RL7
			assign cfg_rej[c] = sel[c] & is_cfg & send_busy[c]; // RL7
			assign cfg_load[c] = sel[c] & is_cfg & !send_busy[c];
			assign proto_rej[c] = sel[c] & is_proto & send_busy[c]; // RL8
			assign ev[c] = fin[c] | rej_send[c];
			assign ev_err[c] = (fin[c] & fin_err[c]) | rej_send[c]; // RL11
			assign wr_en[c] = wr & a_data &
				(pwdata[bidir_send_pkg::DATA_CH_BIT] == 1'(c));

			bidir_tx_channel #(
				.DEPTH(DEPTH),
				.AW(AW),
				.W(16)
			) u_tx (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(wr_en[c]),
				.wr_idx(pwdata[bidir_send_pkg::DATA_IDX_LSB +: AW]),
				.wr_data(pwdata[15:0]),
				.start(start[c]),
				.len(send_len_r), // RL4
				.byte_units(byte_units_r),
				.link_ack(ack_s_r[c]),
				.link_fault(flt_s_r[c]),
				.tx_data_r(tx_data[c]),
				.tx_valid_r(tx_valid[c]),
				.busy(send_busy[c]),
				.fin_r(fin[c]),
				.fin_err(fin_err[c]),
				.fin_code_r(fin_code[c])
			);

			scan_end_reporter u_rep (
				.pclk(pclk),
				.presetn(presetn),
				.event_in(ev[c]),
				.event_err(ev_err[c]),
				.scan_end(scan_end),
				.done_r(rep_done[c]),
				.abn_r(rep_abn[c])
			);

			AST_BUSY_IGNORED: assert property ( // RL6
				@(posedge pclk) disable iff (!presetn)
				(sel[c] && is_send && send_busy[c]) |=>
					(result_r[c] == $past(result_r[c]) || $past(fin[c])))
				else $error("send on busy channel was not ignored");

			AST_SEND_AFTER_CFG: assert property ( // RL7
				@(posedge pclk) disable iff (!presetn)
				rej_send[c] |=>
					(result_r[c] == bidir_send_pkg::ERR_SIMUL_EXEC))
				else $error("send after setting did not fail with 7ff0");

			AST_CFG_AFTER_SEND: assert property ( // RL7
				@(posedge pclk) disable iff (!presetn)
				cfg_rej[c] |=> (cpu_err_flag_r &&
					cmd_result_r == bidir_send_pkg::ERR_SIMUL_EXEC))
				else $error("setting after send did not fail with 7ff0");

			AST_PROTO_CLASH: assert property ( // RL8
				@(posedge pclk) disable iff (!presetn)
				proto_rej[c] |=>
					(cmd_result_r == bidir_send_pkg::ERR_PROTOCOL))
				else $error("protocol clash did not report 7ff2");
		end
	endgenerate

	wire cmd_err = chan_bad | (|cfg_rej) | (|proto_rej) | (|rej_send);
	wire [15:0] cmd_err_code =
		chan_bad ? bidir_send_pkg::ERR_CHANNEL :
		(|proto_rej) ? bidir_send_pkg::ERR_PROTOCOL :
		bidir_send_pkg::ERR_SIMUL_EXEC;
	wire [4:0] irq_set = {cmd_err, ev_err, ev};
	wire [4:0] irq_clr = (wr & a_iclr) ? pwdata[4:0] : 5'h00;
	wire [4:0] irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;

	// Link pins pass two flip-flops first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_m_r <= 2'h0;
			ack_s_r <= 2'h0;
			flt_m_r <= 2'h0;
			flt_s_r <= 2'h0;
		end else begin
			ack_m_r <= tx_ack;
			ack_s_r <= ack_m_r;
			flt_m_r <= tx_fault;
			flt_s_r <= flt_m_r;
		end
	end

	// Slave answers in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= acc & !pready_r;
			prdata_r <= (acc & !pready_r & !pwrite) ? rd_val : 32'h00000000;
			pslverr_r <= acc & !pready_r & !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			send_len_r <= bidir_send_pkg::RST_HALF;
			byte_units_r <= 1'b0;
			irq_en_r <= bidir_send_pkg::RST_IRQ;
		end else if (wr) begin
			if (a_len) send_len_r <= pwdata[15:0];
			if (a_cfg) byte_units_r <= pwdata[0];
			if (a_ien) irq_en_r <= pwdata[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_r <= '0;
			cfg_cnt_r <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ev[i]) begin
					result_r[i] <= rej_send[i] ? bidir_send_pkg::ERR_SIMUL_EXEC :
						fin_code[i]; // RL3 RL11
				end else if (wr & (i == 0 ? a_res1 : a_res2)) begin
					result_r[i] <= pwdata[15:0];
				end
				if (cfg_load[i]) begin
					cfg_cnt_r[i] <= bidir_send_pkg::CFG_CNT_LOAD;
				end else if (cfg_busy[i]) begin
					cfg_cnt_r[i] <= cfg_cnt_r[i] - 8'h01;
				end
			end
		end
	end

	// Error flag: a new error wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_result_r <= bidir_send_pkg::RESULT_NORMAL;
			cpu_err_flag_r <= 1'b0;
			cpu_err_code_r <= bidir_send_pkg::RESULT_NORMAL;
		end else begin
			if (issue) begin
				cmd_result_r <= cmd_err ? cmd_err_code :
					bidir_send_pkg::RESULT_NORMAL; // RL13
			end
			if (cmd_err) begin
				cpu_err_flag_r <= 1'b1; // RL12
				cpu_err_code_r <= cmd_err_code; // RL12
			end else if (wr & a_cpu) begin
				cpu_err_flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_r <= bidir_send_pkg::RST_IRQ;
			irq_r <= 1'b0;
		end else begin
			irq_st_r <= irq_st_nxt;
			irq_r <= |(irq_st_nxt & irq_en_r);
		end
	end

	AST_APB_ANSWER: assert property (
		@(posedge pclk) disable iff (!presetn)
		(acc && !pready_r) |=> (pready_r ##1 !pready_r))
		else $error("slave did not answer in the second access cycle");

	AST_CPU_ERR: assert property ( // RL12
		@(posedge pclk) disable iff (!presetn)
		chan_bad |=> (cpu_err_flag_r &&
			cpu_err_code_r == bidir_send_pkg::ERR_CHANNEL))
		else $error("operation error not flagged to processor");

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign done_bit = rep_done;
	assign abnormal_bit = rep_abn;
	assign cpu_error_flag = cpu_err_flag_r;
	assign cpu_error_code_word = cpu_err_code_r;
	assign irq = irq_r;

endmodule

// [sim/link_sink.sv]
`timescale 1ns/1ns
module link_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] tx_data,
	input wire logic tx_valid,
	input wire logic [7:0] lag,
	input wire logic fault_req,
	output logic tx_ack,
	output logic tx_fault,
	output logic [15:0] last_word,
	output logic [7:0] words
);
	logic [7:0] wait_r;

	// Four-phase acknowledge after a programmable delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ack <= 1'h0;
			tx_fault <= 1'h0;
			last_word <= 16'h0000;
			words <= 8'h00;
			wait_r <= 8'h00;
		end else begin
			tx_fault <= fault_req;
			if (!tx_valid) begin
				tx_ack <= 1'h0;
				wait_r <= 8'h00;
			end else if (!tx_ack && wait_r >= lag) begin
				tx_ack <= 1'h1;
				last_word <= tx_data;
				words <= words + 8'h01;
				wait_r <= 8'h00;
			end else if (!tx_ack) begin
				wait_r <= wait_r + 8'h01;
			end
		end
	end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end
module testbench;
	typedef struct {
		logic [1:0] ch;
		logic [15:0] len;
		logic bu;
		logic [15:0] code;
		int nw;
	} row_t;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, irq, cpu_error_flag, slv;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [1:0][15:0] tx_data, last_word;
	logic [1:0][7:0] words;
	logic [1:0] tx_valid, tx_ack, tx_fault, done_bit, abnormal_bit;
	logic [1:0] fault_req = 2'h0;
	logic [7:0] lag0 = 8'h02, lag1 = 8'h02, w0;
	logic [15:0] cpu_error_code_word;
	logic [3:0] ok_codes [5] = '{4'h2, 4'ha, 4'hb, 4'hc, 4'hd};
	int checks = 0, bad_count = 0, cyc = 0;
	row_t rows [5] = '{
		'{2'h1, 16'h0002, 1'h0, 16'h0000, 2},
		'{2'h2, 16'h0003, 1'h1, 16'h0000, 2},
		'{2'h1, 16'h0010, 1'h0, 16'h0000, 16},
		'{2'h2, 16'h0000, 1'h0, 16'h7f11, 0},
		'{2'h1, 16'h0011, 1'h0, 16'h7f11, 0}};
	row_t slow_row = '{2'h1, 16'h0002, 1'h0, 16'h0000, 2};

	always #10 pclk = ~pclk;

	bidir_send_handler dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ack(tx_ack),
		.tx_fault(tx_fault), .done_bit(done_bit), .abnormal_bit(abnormal_bit),
		.cpu_error_flag(cpu_error_flag),
		.cpu_error_code_word(cpu_error_code_word), .irq(irq));
	link_sink link_u0 (.pclk(pclk), .presetn(presetn), .tx_data(tx_data[0]),
		.tx_valid(tx_valid[0]), .lag(lag0), .fault_req(fault_req[0]),
		.tx_ack(tx_ack[0]), .tx_fault(tx_fault[0]),
		.last_word(last_word[0]), .words(words[0]));
	link_sink link_u1 (.pclk(pclk), .presetn(presetn), .tx_data(tx_data[1]),
		.tx_valid(tx_valid[1]), .lag(lag1), .fault_req(fault_req[1]),
		.tx_ack(tx_ack[1]), .tx_fault(tx_fault[1]),
		.last_word(last_word[1]), .words(words[1]));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			$display("ERROR timeout expected %h seen %h", 0, cyc);
			print_verdict();
		end
	end

	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) begin
			n++;
			@(posedge pclk);
		end
		`CHK("wait_states", 1, n)
		q = prdata;
		slv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	function automatic logic [31:0] cmdw(input logic [3:0] c,
			input logic [1:0] ch, input logic [7:0] sio);
		return {16'h0000, sio, 2'h0, ch, c};
	endfunction

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	task automatic launch(input row_t r);
		for (int i = 0; i < r.nw; i++)
			apb(1'h1, bidir_send_pkg::OFF_DATA_WR, {r.ch == 2'h2, 11'h000,
				4'(i), 16'ha500 + 16'(i)});
		apb(1'h1, bidir_send_pkg::OFF_SEND_LEN, {16'h0000, r.len});
		apb(1'h1, bidir_send_pkg::OFF_CONFIG, {31'h0, r.bu});
		apb(1'h1, bidir_send_pkg::OFF_CMD, cmdw(4'h1, r.ch, 8'h00));
	endtask

	task automatic finish(input row_t r, input logic [7:0] wb);
		int c;
		c = int'(r.ch) - 1;
		q = 32'h30;
		while (q[4 + c] !== 1'h0) begin
			apb(1'h0, bidir_send_pkg::OFF_COMPLETION, 32'h0);
		end
		apb(1'h1, bidir_send_pkg::OFF_SCAN_END, 32'h0);
		`CHK("done", 1'h1, done_bit[c])
		`CHK("abnormal", r.code != 16'h0, abnormal_bit[c])
		apb(1'h0, c ? bidir_send_pkg::OFF_RESULT2
			: bidir_send_pkg::OFF_RESULT1, 32'h0);
		`CHK("result", r.code, q[15:0])
		if (r.code === 16'h0000) begin
			`CHK("words", 8'(r.nw), 8'(words[c] - wb))
			`CHK("last", 16'ha4ff + 16'(r.nw), last_word[c])
		end
		apb(1'h1, bidir_send_pkg::OFF_SCAN_END, 32'h0);
		`CHK("done_off", 2'h0, {done_bit[c], abnormal_bit[c]})
	endtask

	task automatic run(input row_t r);
		logic [7:0] wb;
		wb = words[r.ch - 2'h1];
		launch(r);
		finish(r, wb);
	endtask

	task automatic cmd(input logic [3:0] c, input logic [1:0] ch,
			input logic [15:0] e);
		apb(1'h1, bidir_send_pkg::OFF_CMD, cmdw(c, ch, 8'h00));
		apb(1'h0, bidir_send_pkg::OFF_CMD_RESULT, 32'h0);
		`CHK("cmd_result", e, q[15:0])
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h1, bidir_send_pkg::OFF_IRQ_ENABLE, 32'h1f);
		foreach (rows[i])
			run(rows[i]);
		apb(1'h0, bidir_send_pkg::OFF_IRQ_STATUS, 32'h0);
		`CHK("irq_status", 6'h2f, {irq, q[4:0]})
		tdone("table");
		apb(1'h1, bidir_send_pkg::OFF_IRQ_CLEAR, 32'h1f);
		apb(1'h1, bidir_send_pkg::OFF_IRQ_ENABLE, 32'h0f);
		apb(1'h1, bidir_send_pkg::OFF_CMD, cmdw(4'h1, 2'h3, 8'h01));
		apb(1'h0, bidir_send_pkg::OFF_IRQ_STATUS, 32'h0);
		`CHK("foreign_io", 6'h00, {irq, q[4:0]})
		apb(1'h1, bidir_send_pkg::OFF_CMD, cmdw(4'h1, 2'h3, 8'h00));
		apb(1'h0, bidir_send_pkg::OFF_CPU_ERR, 32'h0);
		`CHK("bad_channel", 18'h17f10, {irq, q[16:0]})
		apb(1'h1, bidir_send_pkg::OFF_IRQ_ENABLE, 32'h1f);
		apb(1'h0, bidir_send_pkg::OFF_IRQ_STATUS, 32'h0);
		`CHK("unmasked", 6'h30, {irq, q[4:0]})
		apb(1'h1, bidir_send_pkg::OFF_IRQ_CLEAR, 32'h1f);
		apb(1'h0, 12'h040, 32'h0);
		`CHK("unmapped", 33'h100000000, {slv, q})
		tdone("irq");
		lag0 <= 8'hc8;
		w0 = words[0];
		launch(slow_row);
		apb(1'h1, bidir_send_pkg::OFF_CMD, cmdw(4'h1, 2'h1, 8'h00));
		cmd(4'h3, 2'h1, 16'h7ff0);
		`CHK("cpu_err", 17'h17ff0, {cpu_error_flag, cpu_error_code_word})
		cmd(4'h4, 2'h1, 16'h7ff0);
		for (int c = 5; c <= 9; c++)
			cmd(4'(c), 2'h1, 16'h7ff2);
		foreach (ok_codes[i])
			cmd(ok_codes[i], 2'h1, 16'h0000);
		cmd(4'h4, 2'h2, 16'h0000);
		finish(slow_row, w0);
		cmd(4'h3, 2'h2, 16'h0000);
		run(row_t'{2'h2, 16'h0001, 1'h0, 16'h7ff0, 0});
		tdone("collisions");
		lag0 <= 8'h28;
		launch(slow_row);
		fault_req <= 2'h1;
		finish(row_t'{2'h1, 16'h0002, 1'h0, 16'h7f12, 2}, w0);
		fault_req <= 2'h0;
		tdone("link_fault");
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		`CHK("reset", 7'h00, {done_bit, abnormal_bit, cpu_error_flag, irq,
			tx_valid[0]})
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, bidir_send_pkg::OFF_RESULT1, 32'h0);
		`CHK("result_reset", 16'h0000, q[15:0])
		tdone("reset");
		print_verdict();
	end
endmodule
